// *** inc/dbmac_defines.svh ***
// Constants of the background debug memory and register command executor.
// Assumes inclusion by the executor only.
`ifndef DBMAC_DEFINES_SVH
`define DBMAC_DEFINES_SVH

// Command word fields
`define DBMAC_OP_MSB       15
`define DBMAC_OP_LSB       10
`define DBMAC_RW_BIT       8
`define DBMAC_SIZE_MSB     7
`define DBMAC_SIZE_LSB     6
`define DBMAC_AD_BIT       3
`define DBMAC_REG_MSB      2

// Operation codes (bits 15:10)
`define DBMAC_OP_NOP       6'h00
`define DBMAC_OP_WREG      6'h08
`define DBMAC_OP_MEM       6'h06
`define DBMAC_OP_BLOCK     6'h07

// Operand size codes
`define DBMAC_SZ_BYTE      2'h0
`define DBMAC_SZ_WORD      2'h1
`define DBMAC_SZ_LONG      2'h2

// Responses, status bit first
`define DBMAC_RSP_COMPLETE 17'h0ffff
`define DBMAC_RSP_NOTREADY 17'h10000
`define DBMAC_RSP_ILLEGAL  17'h1ffff
`define DBMAC_RSP_BUSERR   17'h10001

// Link framing
`define DBMAC_FRAME_LAST   5'h10

// APB map
`define DBMAC_ADDR_BREAKPOINT_ADDRESS_ATTR_REG    8'h00
`define DBMAC_ADDR_STATUS  8'h04
`define DBMAC_ADDR_PTR     8'h08
`define DBMAC_BREAKPOINT_ADDRESS_ATTR_REG_TM_LSB  0
`define DBMAC_BREAKPOINT_ADDRESS_ATTR_REG_TT_LSB  3
`define DBMAC_BREAKPOINT_ADDRESS_ATTR_REG_RESET   5'h00

`endif

// *** inc/dbmac_pkg.sv ***
// Types of the background debug command executor.
// Assumes nothing of its surroundings.
package dbmac_pkg;

   typedef enum logic [2:0] {
      DBMAC_IDLE    = 3'h0,
      DBMAC_ADDR_HI = 3'h1,
      DBMAC_ADDR_LO = 3'h3,
      DBMAC_DATA_HI = 3'h2,
      DBMAC_DATA_LO = 3'h6,
      DBMAC_MEM     = 3'h7,
      DBMAC_RES_LO  = 3'h5
   } dbmac_state_t;

   typedef enum logic [2:0] {
      DBMAC_CK_NOP   = 3'h0,
      DBMAC_CK_WREG  = 3'h1,
      DBMAC_CK_READ  = 3'h2,
      DBMAC_CK_WRITE = 3'h3,
      DBMAC_CK_DUMP  = 3'h4,
      DBMAC_CK_FILL  = 3'h5,
      DBMAC_CK_OTHER = 3'h6
   } dbmac_cmd_t;

   typedef enum logic [1:0] {
      DBMAC_SEQ_NONE = 2'h0,
      DBMAC_SEQ_RD   = 2'h1,
      DBMAC_SEQ_WR   = 2'h2
   } dbmac_seq_t;

endpackage

// *** verilog/dbmac_cmd_exec.sv ***
// Command executor of the background debug link: register write, memory
// read and write, block dump and block fill, plus an APB register slave.
// Assumes the core and memory port share sys_clk; link pins are async.
`include "dbmac_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dbmac_cmd_exec (
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        dsClk,
   input  wire logic        dsIn,
   output logic             dsOut,
   input  wire logic        coreHalted,
   output logic             regWe,
   output logic [3:0]       regSel,
   output logic [31:0]      regWdata,
   output logic             memReq,
   output logic             memWrite,
   output logic [31:0]      memAddr,
   output logic [1:0]       memSize,
   output logic [31:0]      memWdata,
   output logic [1:0]       memTt,
   output logic [2:0]       memTm,
   input  wire logic        memDone,
   input  wire logic        memErr,
   input  wire logic [31:0] memRdata,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   function automatic logic [31:0] sizeBytes(input logic [1:0] sz);
      case (sz)
         `DBMAC_SZ_BYTE: sizeBytes = 32'h1;
         `DBMAC_SZ_WORD: sizeBytes = 32'h2;
         default:        sizeBytes = 32'h4;
      endcase
   endfunction

   // Size code 2'h3 is treated as longword
   function automatic logic [31:0] alignAddr(input logic [31:0] a,
                                             input logic [1:0]  sz);
      case (sz)
         `DBMAC_SZ_BYTE: alignAddr = a;
         `DBMAC_SZ_WORD: alignAddr = {a[31:1], 1'b0};
         default:        alignAddr = {a[31:2], 2'b00};
      endcase
   endfunction

   function automatic dbmac_pkg::dbmac_cmd_t decodeCmd(
      input logic [15:0] w);
      logic [5:0] op;
      op = w[`DBMAC_OP_MSB:`DBMAC_OP_LSB];
      if (w == 16'h0000)
         decodeCmd = dbmac_pkg::DBMAC_CK_NOP;
      else if (op == `DBMAC_OP_WREG && !w[`DBMAC_RW_BIT])
         decodeCmd = dbmac_pkg::DBMAC_CK_WREG;
      else if (op == `DBMAC_OP_MEM)
         decodeCmd = w[`DBMAC_RW_BIT] ? dbmac_pkg::DBMAC_CK_READ
                                      : dbmac_pkg::DBMAC_CK_WRITE;
      else if (op == `DBMAC_OP_BLOCK)
         decodeCmd = w[`DBMAC_RW_BIT] ? dbmac_pkg::DBMAC_CK_DUMP
                                      : dbmac_pkg::DBMAC_CK_FILL;
      else
         decodeCmd = dbmac_pkg::DBMAC_CK_OTHER;
   endfunction

   // Link pins: two flops before any logic, third flop for edges
   logic [2:0]  clkSync_reg;
   logic [1:0]  dinSync_reg;
   logic [4:0]  bitCnt_reg;
   logic [15:0] rxShift_reg;
   logic [16:0] txShift_reg;
   logic [16:0] resp_reg;
   logic        linkRise;
   logic        linkFall;
   logic        frameEnd;
   logic [15:0] rxWord;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         clkSync_reg <= 3'h0;
         dinSync_reg <= 2'h0;
      end else begin
         clkSync_reg <= {clkSync_reg[1:0], dsClk};
         dinSync_reg <= {dinSync_reg[0], dsIn};
      end
   end

   assign linkRise = clkSync_reg[1] & ~clkSync_reg[2];
   assign linkFall = ~clkSync_reg[1] & clkSync_reg[2];
   assign frameEnd = linkRise && (bitCnt_reg == `DBMAC_FRAME_LAST);
   // Last 16 bits of the 17-bit frame; the host's leading bit is unused
   assign rxWord   = {rxShift_reg[14:0], dinSync_reg[1]};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bitCnt_reg  <= 5'h0;
         rxShift_reg <= 16'h0;
      end else if (linkRise) begin
         rxShift_reg <= rxWord;
         bitCnt_reg  <= frameEnd ? 5'h0 : bitCnt_reg + 5'h1;
      end
   end

   // Reloaded until the first edge so a late result still goes out
   always_ff @(posedge sys_clk) begin
      if (rst)
         txShift_reg <= `DBMAC_RSP_COMPLETE;
      else if (bitCnt_reg == 5'h0 && !linkRise)
         txShift_reg <= resp_reg;
      else if (linkFall && bitCnt_reg != 5'h0)
         txShift_reg <= {txShift_reg[15:0], 1'b0};
   end

   assign dsOut = txShift_reg[16];

   // Command engine
   dbmac_pkg::dbmac_state_t state_reg;
   dbmac_pkg::dbmac_cmd_t   cmd_reg;
   dbmac_pkg::dbmac_cmd_t   rxCmd;
   dbmac_pkg::dbmac_seq_t   seq_reg;
   logic [1:0]              size_reg;
   logic [1:0]              rxSize;
   logic [31:0]             addr_reg;
   logic [31:0]             ptr_reg;
   logic [15:0]             dataHi_reg;
   logic [15:0]             loHold_reg;
   logic [31:0]             fullData;
   logic [4:0]              breakpoint_address_attr_reg_reg;

   assign rxCmd    = decodeCmd(rxWord);
   assign rxSize   = rxWord[`DBMAC_SIZE_MSB:`DBMAC_SIZE_LSB];
   // Byte operands arrive with an undefined upper byte, so it is cut off
   assign fullData = (size_reg == `DBMAC_SZ_LONG) ?
                     {dataHi_reg, rxWord} :
                     (size_reg == `DBMAC_SZ_BYTE) ?
                     {24'h000000, rxWord[7:0]} :
                     {16'h0000, rxWord};

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg  <= dbmac_pkg::DBMAC_IDLE;
         cmd_reg    <= dbmac_pkg::DBMAC_CK_NOP;
         seq_reg    <= dbmac_pkg::DBMAC_SEQ_NONE;
         size_reg   <= `DBMAC_SZ_BYTE;
         addr_reg   <= 32'h0;
         ptr_reg    <= 32'h0;
         dataHi_reg <= 16'h0;
         loHold_reg <= 16'h0;
         resp_reg   <= `DBMAC_RSP_COMPLETE;
         regWe      <= 1'b0;
         regSel     <= 4'h0;
         regWdata   <= 32'h0;
         memReq     <= 1'b0;
         memWrite   <= 1'b0;
         memAddr    <= 32'h0;
         memSize    <= `DBMAC_SZ_BYTE;
         memWdata   <= 32'h0;
      end else begin
         regWe <= 1'b0;
         if (state_reg == dbmac_pkg::DBMAC_MEM) begin
            // Frames ending here are dropped; not-ready stays loaded
            if (memDone) begin
               memReq  <= 1'b0;
               ptr_reg <= memAddr + sizeBytes(memSize);
               state_reg <= dbmac_pkg::DBMAC_IDLE;
               if (memErr)
                  resp_reg <= `DBMAC_RSP_BUSERR;
               else if (memWrite)
                  resp_reg <= `DBMAC_RSP_COMPLETE;
               else begin
                  case (memSize)
                     `DBMAC_SZ_BYTE:
                        resp_reg <= {9'h000, memRdata[7:0]};
                     `DBMAC_SZ_WORD:
                        resp_reg <= {1'b0, memRdata[15:0]};
                     default: begin
                        resp_reg   <= {1'b0, memRdata[31:16]};
                        loHold_reg <= memRdata[15:0];
                        state_reg  <= dbmac_pkg::DBMAC_RES_LO;
                     end
                  endcase
               end
            end
         end else if (frameEnd) begin
            case (state_reg)
               dbmac_pkg::DBMAC_IDLE: begin
                  cmd_reg  <= rxCmd;
                  size_reg <= rxSize;
                  regSel   <= {rxWord[`DBMAC_AD_BIT],
                               rxWord[`DBMAC_REG_MSB:0]};
                  resp_reg <= `DBMAC_RSP_NOTREADY;
                  case (rxCmd)
                     dbmac_pkg::DBMAC_CK_NOP:
                        resp_reg <= `DBMAC_RSP_COMPLETE;
                     dbmac_pkg::DBMAC_CK_WREG: begin
                        seq_reg   <= dbmac_pkg::DBMAC_SEQ_NONE;
                        state_reg <= dbmac_pkg::DBMAC_DATA_HI;
                     end
                     dbmac_pkg::DBMAC_CK_READ: begin
                        seq_reg   <= dbmac_pkg::DBMAC_SEQ_RD;
                        state_reg <= dbmac_pkg::DBMAC_ADDR_HI;
                     end
                     dbmac_pkg::DBMAC_CK_WRITE: begin
                        seq_reg   <= dbmac_pkg::DBMAC_SEQ_WR;
                        state_reg <= dbmac_pkg::DBMAC_ADDR_HI;
                     end
                     dbmac_pkg::DBMAC_CK_DUMP: begin
                        if (seq_reg == dbmac_pkg::DBMAC_SEQ_RD) begin
                           // Pointer aligned to the new size, never range checked
                           memAddr   <= alignAddr(ptr_reg, rxSize);
                           memSize   <= rxSize;
                           memWrite  <= 1'b0;
                           memReq    <= 1'b1;
                           state_reg <= dbmac_pkg::DBMAC_MEM;
                        end else begin
                           resp_reg <= `DBMAC_RSP_ILLEGAL;
                           seq_reg  <= dbmac_pkg::DBMAC_SEQ_NONE;
                        end
                     end
                     dbmac_pkg::DBMAC_CK_FILL: begin
                        if (seq_reg == dbmac_pkg::DBMAC_SEQ_WR)
                           state_reg <= (rxSize == `DBMAC_SZ_LONG) ?
                                        dbmac_pkg::DBMAC_DATA_HI :
                                        dbmac_pkg::DBMAC_DATA_LO;
                        else begin
                           resp_reg <= `DBMAC_RSP_ILLEGAL;
                           seq_reg  <= dbmac_pkg::DBMAC_SEQ_NONE;
                        end
                     end
                     default: begin
                        resp_reg <= `DBMAC_RSP_ILLEGAL;
                        seq_reg  <= dbmac_pkg::DBMAC_SEQ_NONE;
                     end
                  endcase
               end
               dbmac_pkg::DBMAC_ADDR_HI: begin
                  addr_reg[31:16] <= rxWord;
                  state_reg       <= dbmac_pkg::DBMAC_ADDR_LO;
               end
               dbmac_pkg::DBMAC_ADDR_LO: begin
                  addr_reg[15:0] <= rxWord;
                  if (cmd_reg == dbmac_pkg::DBMAC_CK_READ) begin
                     memAddr   <= alignAddr({addr_reg[31:16], rxWord},
                                            size_reg);
                     memSize   <= size_reg;
                     memWrite  <= 1'b0;
                     memReq    <= 1'b1;
                     state_reg <= dbmac_pkg::DBMAC_MEM;
                  end else
                     state_reg <= (size_reg == `DBMAC_SZ_LONG) ?
                                  dbmac_pkg::DBMAC_DATA_HI :
                                  dbmac_pkg::DBMAC_DATA_LO;
               end
               dbmac_pkg::DBMAC_DATA_HI: begin
                  dataHi_reg <= rxWord;
                  state_reg  <= dbmac_pkg::DBMAC_DATA_LO;
               end
               dbmac_pkg::DBMAC_DATA_LO: begin
                  if (cmd_reg == dbmac_pkg::DBMAC_CK_WREG) begin
                     state_reg <= dbmac_pkg::DBMAC_IDLE;
                     if (coreHalted) begin
                        regWdata <= {dataHi_reg, rxWord};
                        regWe    <= 1'b1;
                        resp_reg <= `DBMAC_RSP_COMPLETE;
                     end else
                        resp_reg <= `DBMAC_RSP_BUSERR;
                  end else begin
                     memAddr  <= alignAddr(
                        (cmd_reg == dbmac_pkg::DBMAC_CK_FILL) ?
                        ptr_reg : addr_reg, size_reg);
                     memSize   <= size_reg;
                     memWdata  <= fullData;
                     memWrite  <= 1'b1;
                     memReq    <= 1'b1;
                     state_reg <= dbmac_pkg::DBMAC_MEM;
                  end
               end
               dbmac_pkg::DBMAC_RES_LO: begin
                  resp_reg  <= {1'b0, loHold_reg};
                  state_reg <= dbmac_pkg::DBMAC_IDLE;
               end
               default:
                  state_reg <= dbmac_pkg::DBMAC_IDLE;
            endcase
         end
      end
   end

   // Address space attributes steer every debug memory access
   assign memTt = breakpoint_address_attr_reg_reg[`DBMAC_BREAKPOINT_ADDRESS_ATTR_REG_TT_LSB +: 2];
   assign memTm = breakpoint_address_attr_reg_reg[`DBMAC_BREAKPOINT_ADDRESS_ATTR_REG_TM_LSB +: 3];

   // APB slave: zero wait states, unmapped addresses raise pslverr
   logic apbHit;

   assign apbHit  = (paddr == `DBMAC_ADDR_BREAKPOINT_ADDRESS_ATTR_REG)   ||
                    (paddr == `DBMAC_ADDR_STATUS) ||
                    (paddr == `DBMAC_ADDR_PTR);
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~apbHit;

   always_ff @(posedge sys_clk) begin
      if (rst)
         breakpoint_address_attr_reg_reg <= `DBMAC_BREAKPOINT_ADDRESS_ATTR_REG_RESET;
      else if (psel && penable && pwrite &&
               paddr == `DBMAC_ADDR_BREAKPOINT_ADDRESS_ATTR_REG)
         breakpoint_address_attr_reg_reg <= pwdata[4:0];
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         prdata <= 32'h0;
      else if (psel && !penable) begin
         case (paddr)
            `DBMAC_ADDR_BREAKPOINT_ADDRESS_ATTR_REG:   prdata <= {27'h0, breakpoint_address_attr_reg_reg};
            `DBMAC_ADDR_STATUS: prdata <= {24'h0, coreHalted, memReq,
                                           seq_reg, 1'b0, state_reg};
            `DBMAC_ADDR_PTR:    prdata <= ptr_reg;
            default:            prdata <= 32'h0;
         endcase
      end
   end

endmodule

`default_nettype wire

// *** verification/dbmac_checker.sv ***
// Port checker of the debug command executor, bound to its top module.
// Assumes the checker sees only the executor's ports.
`timescale 1ns/1ps
`default_nettype none
module dbmac_checker (
   input wire logic        sys_clk,
   input wire logic        rst,
   input wire logic        regWe,
   input wire logic        coreHalted,
   input wire logic        memReq,
   input wire logic        memDone,
   input wire logic        memWrite,
   input wire logic [31:0] memAddr,
   input wire logic [1:0]  memSize,
   input wire logic [31:0] memWdata,
   input wire logic [1:0]  memTt,
   input wire logic [2:0]  memTm,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata
);
   logic [4:0] attrReg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Shadow of the attribute register, so no internals are needed
   always_ff @(posedge sys_clk) begin
      if (rst)
         attrReg <= 5'h00;
      else if (psel && penable && pwrite && paddr == 8'h00)
         attrReg <= pwdata[4:0];
   end
   property p_attr; memReq |-> {memTt, memTm} == attrReg; endproperty
   a_attr: assert property (p_attr) else $error("Bad space");
   property p_word; memReq && memSize == 2'h1 |-> !memAddr[0]; endproperty
   a_word: assert property (p_word) else $error("Odd word");
   property p_long; memReq && memSize[1] |-> memAddr[1:0] == 2'h0;
   endproperty
   a_long: assert property (p_long) else $error("Odd long");
   property p_hold; memReq && !memDone |=>
      memReq && $stable({memAddr, memSize, memWrite, memWdata}); endproperty
   a_hold: assert property (p_hold) else $error("Access moved");
   property p_drop; memDone |=> !memReq; endproperty
   a_drop: assert property (p_drop) else $error("Access stuck");
   property p_pulse; regWe |=> !regWe; endproperty
   a_pulse: assert property (p_pulse) else $error("Long strobe");
   property p_halt; regWe |-> coreHalted; endproperty
   a_halt: assert property (p_halt) else $error("Write running");
   property p_wdata; memReq && memWrite && !memSize[1] |->
      (memWdata >> (memSize[0] ? 16 : 8)) == 32'h0; endproperty
   a_wdata: assert property (p_wdata) else $error("Wide data");
endmodule
bind dbmac_cmd_exec dbmac_checker i_dbmac_checker (.sys_clk, .rst, .regWe,
   .coreHalted, .memReq, .memDone, .memWrite, .memAddr, .memSize,
   .memWdata, .memTt, .memTm, .psel, .penable, .pwrite, .paddr, .pwdata);
`default_nettype wire

// *** verification/dbmac_host.sv ***
// Development system model: shifts 17-bit frames over the debug link.
// Assumes the link clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module dbmac_host (
   output logic      dsClk,
   output logic      dsIn,
   input  wire logic dsOut
);
   initial begin
      dsClk = 1'b0;
      dsIn = 1'b1;
   end
   // Word sent MSB first; reply bit read just before each rise
   task automatic frame(input logic [15:0] w, output logic [16:0] r);
      for (int i = 16; i >= 0; i--) begin
         dsIn = (i == 16) ? 1'b0 : w[i];
         #40 r[i] = dsOut;
         dsClk = 1'b1;
         #40 dsClk = 1'b0;
      end
      dsIn = ~w[0]; // Released line must not keep the last bit
      #150;
   endtask
endmodule
`default_nettype wire

// *** verification/debug_register_memory_access_cmds_test.sv ***
// Bench of the debug command executor: link host, memory and APB sides.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module debug_register_memory_access_cmds_test;
   logic        sys_clk, rst, dsClk, dsIn, dsOut, coreHalted, regWe;
   logic        memReq, memWrite, memDone, memErr, psel, penable, pwrite;
   logic        pready, pslverr, capWr, pend, memFail;
   logic [1:0]  memSize, memTt, capSize;
   logic [2:0]  memTm;
   logic [3:0]  regSel, capSel;
   logic [4:0]  capAttr;
   logic [7:0]  paddr;
   logic [31:0] regWdata, memAddr, memWdata, memRdata, pwdata, prdata;
   logic [31:0] capAddr, capWdata, capWd;
   int          num_errors, cmp_count, weCnt, memLat, waitN;

   dbmac_cmd_exec i_dbmac_cmd_exec (.sys_clk, .rst, .dsClk, .dsIn, .dsOut,
      .coreHalted, .regWe, .regSel, .regWdata, .memReq, .memWrite, .memAddr,
      .memSize, .memWdata, .memTt, .memTm, .memDone, .memErr, .memRdata,
      .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   dbmac_host i_dbmac_host (.dsClk, .dsIn, .dsOut);

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Memory raises memDone memLat + 2 cycles after memReq rises; register strobes are logged
   always @(posedge sys_clk) begin
      memDone <= 1'b0;
      if (memReq && !memDone && !pend) begin
         pend <= 1'b1;
         waitN <= 0;
         {capWr, capAddr, capSize, capWdata} <= {memWrite, memAddr,
            memSize, memWdata};
         capAttr <= {memTt, memTm};
      end else if (pend) begin
         waitN <= waitN + 1;
         if (waitN == memLat) begin
            {memDone, memErr, pend} <= {1'b1, memFail, 1'b0};
            memRdata <= {~memAddr[15:0], memAddr[15:0]};
         end
      end
      if (regWe) begin
         weCnt <= weCnt + 1;
         {capSel, capWd} <= {regSel, regWdata};
      end
   end
   task automatic wrap_up();
      $display("Compares %0d, errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [71:0] s, e);
      cmp_count++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h want %h", $time, s, e);
      end
   endtask
   task automatic tmo();
      num_errors++;
      $display("[FAIL] %0t wait ran out", $time);
      wrap_up();
   endtask
   task automatic fr(input logic [15:0] w);
      logic [16:0] r;
      i_dbmac_host.frame(w, r);
   endtask
   task automatic fc(input logic [15:0] w, input logic [16:0] e);
      logic [16:0] r;
      i_dbmac_host.frame(w, r);
      chk(r, e);
   endtask
   task automatic wmem();
      int n;
      for (n = 0; n < 2000; n++) begin
         @(negedge sys_clk);
         if (memReq === 1'b0 && !pend) break;
      end
      if (n == 2000) tmo();
   endtask
   task automatic apb(input logic [7:0] a, input logic w,
                      input logic [31:0] wd, output logic [31:0] rd,
                      output logic err);
      int n;
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
      @(posedge sys_clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      {rd, err} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
      if (n == 20) tmo();
   endtask
   task automatic s_wreg();
      int n;
      for (int h = 1; h >= 0; h--) begin
         @(posedge sys_clk);
         coreHalted <= h[0];
         n = weCnt;
         fr(16'h208b);
         fc(16'h1234, 17'h10000);
         fc(16'habcd, 17'h10000);
         fc(16'h0000, h ? 17'h0ffff : 17'h10001);
         chk(weCnt - n, h);
      end
      chk({capSel, capWd}, {4'hb, 32'h1234abcd});
      fr(16'h1d80);
      fc(16'h1c00, 17'h1ffff);
      fc(16'h0000, 17'h1ffff);
   endtask
   task automatic s_dump();
      logic [16:0] r;
      logic [31:0] d;
      logic        e;
      apb(8'h00, 1'b1, 32'h1d, d, e);
      apb(8'h0c, 1'b1, 32'h3, d, e);
      apb(8'h00, 1'b0, '0, d, e);
      chk(d, 32'h1d);
      apb(8'h0c, 1'b0, '0, d, e);
      chk({e, d}, {1'b1, 32'h0});
      fr(16'h1980);
      fc(16'h0000, 17'h10000);
      fc(16'h1000, 17'h10000);
      wmem();
      chk({capAttr, capSize, capAddr}, {5'h1d, 2'h2, 32'h1000});
      fc(16'h0000, 17'h0efff);
      fc(16'h1d40, 17'h01000);
      wmem();
      chk({capSize, capAddr}, {2'h1, 32'h1004});
      fc(16'h1d00, 17'h01004);
      wmem();
      chk({capSize, capAddr}, {2'h0, 32'h1006});
      apb(8'h08, 1'b0, '0, d, e);
      chk(d, 32'h1007);
      memFail = 1'b1;
      i_dbmac_host.frame(16'h1d80, r);
      chk({r[16], r[7:0]}, 9'h006);
      wmem();
      memFail = 1'b0;
      chk({capSize, capAddr}, {2'h2, 32'h1004});
      fc(16'h0000, 17'h10001);
   endtask
   task automatic s_fill();
      fr(16'h1880);
      fc(16'h0000, 17'h10000);
      fc(16'h2000, 17'h10000);
      fr(16'h89ab);
      fr(16'hcdef);
      wmem();
      chk({capWr, capAddr, capWdata}, {1'b1, 32'h2000, 32'h89abcdef});
      memLat = 400;
      fc(16'h1c40, 17'h0ffff);
      fr(16'h5555);
      fc(16'h0000, 17'h10000);
      wmem();
      memLat = 2;
      chk({capSize, capAddr, capWdata}, {2'h1, 32'h2004, 32'h5555});
      fc(16'h1c00, 17'h0ffff);
      memFail = 1'b1;
      // Upper byte of a byte operand is undefined and must not reach memory
      fr(16'hffa5);
      wmem();
      memFail = 1'b0;
      chk({capSize, capAddr, capWdata}, {2'h0, 32'h2006, 32'ha5});
      fc(16'h1d00, 17'h10001);
      fc(16'h0000, 17'h1ffff);
   endtask
   initial begin
      rst = 1'b1;
      {coreHalted, memDone, memErr, memFail, psel, penable, pwrite} = '0;
      {pend, memRdata, paddr, pwdata, capSel, capWd} = '0;
      {num_errors, cmp_count, weCnt, waitN} = '0;
      memLat = 2;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      s_wreg();
      s_dump();
      s_fill();
      wrap_up();
   end
endmodule
`default_nettype wire
